/* File: bench/sedc_source.sv */
`timescale 1ns/1ps

module sedc_source
    import sedc_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // control from bench
    input wire logic run_in,
    input wire logic [31:0] flip_in,
    input wire sedc_refpair_s ref_first_in,
    input wire sedc_refpair_s ref_second_in,
    // beats towards the checker
    output logic beat_valid_out,
    output sedc_beat_s beat_out
);
    sedc_phase_e phase_reg;

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            phase_reg <= SEDC_PH_FIRST;
            beat_valid_out <= 1'b0;
            beat_out <= '0;
        end else if (run_in) begin
            // first pair then second pair, flip bits inject errors
            beat_valid_out <= 1'b1;
            beat_out <= sedc_beat_s'((phase_reg == SEDC_PH_FIRST ? ref_first_in : ref_second_in) ^ flip_in);
            phase_reg <= (phase_reg == SEDC_PH_FIRST) ? SEDC_PH_SECOND : SEDC_PH_FIRST;
        end else begin
            // idle word toggles so nothing stale looks valid
            beat_valid_out <= 1'b0;
            beat_out <= ~beat_out;
        end
    end
endmodule

/* File: bench/tb_input_sample_error_checker.sv */
`timescale 1ns/1ps

module tb_input_sample_error_checker;
    import sedc_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic rvalid;
    logic run = 1'b0;
    logic [31:0] flip = 32'h0;
    logic [31:0] m1;
    logic [31:0] m2;
    logic sample_err;
    logic fail;
    logic beat_valid;
    sedc_beat_s beat;
    sedc_refpair_s ref_a;
    sedc_refpair_s ref_b;
    logic [7:0] img [0:12];
    logic [7:0] rst_img [0:12];
    logic [7:0] exp_q [$];
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    int seed_v;

    assign ref_a = {img[2], img[1], img[4], img[3]};
    assign ref_b = {img[6], img[5], img[8], img[7]};

    always #5 mclk_in = ~mclk_in;

    sedc_checker #(.CLEAN_RUN(4)) DUT (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .beat_valid_in(beat_valid), .beat_in(beat), .sample_err_out(sample_err), .compare_fail_out(fail)
    );

    sedc_source src (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .run_in(run), .flip_in(flip), .ref_first_in(ref_a),
        .ref_second_in(ref_b), .beat_valid_out(beat_valid), .beat_out(beat)
    );

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (exp_q.size() != 0) n_mismatch++;
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge mclk_in);
        reg_wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge mclk_in);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(negedge mclk_in);
        reg_rd = 1'b1;
        addr = a;
        exp_q.push_back(e);
        @(negedge mclk_in);
        reg_rd = 1'b0;
    endtask

    task automatic chk_all();
        for (int a = 0; a < 13; a++) rd(7'(7'h67 + a), img[a]);
    endtask

    task automatic send(input int n, input logic [31:0] f);
        @(negedge mclk_in);
        run = 1'b1;
        flip = f;
        repeat (n) @(negedge mclk_in);
        run = 1'b0;
        flip = 32'h0;
        repeat (4) @(negedge mclk_in);
    endtask

    task automatic set_mask(input logic [31:0] m);
        img[9] = m[23:16];
        img[10] = m[31:24];
        img[11] = m[7:0];
        img[12] = m[15:8];
    endtask

    // read results come back in request order
    always @(negedge mclk_in) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) check("unexpected read", {7'h00, rvalid}, 8'h00);
            else check("read data", rdata, exp_q.pop_front());
        end
    end

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        rst_img = '{8'h00, 8'h00, 8'h7a, 8'h00, 8'hea, 8'h16, 8'h1a, 8'h00, 8'haa, 8'h00, 8'h00, 8'h00, 8'h00};
        img = rst_img;
        seed_v = $urandom(10225);
        repeat (3) @(negedge mclk_in);
        rst_b_in = 1'b1;
        chk_all();
        for (int a = 1; a < 9; a++) begin
            img[a] = 8'($urandom);
            wr(7'(7'h67 + a), img[a]);
        end
        rd(7'h74, 8'h00);
        chk_all();
        m1 = $urandom | 32'h0001_0001;
        m2 = $urandom | 32'h8000_8000;
        wr(7'h67, 8'h80);
        send(4, 32'h0);
        img[0] = 8'h80;
        chk_all();
        send(2, m1);
        img[0] = 8'ha0;
        set_mask(m1);
        chk_all();
        check("sample_err_out", {7'h00, sample_err}, 8'h01);
        wr(7'h67, 8'h88);
        send(2, 32'h0);
        img[0] = 8'h89;
        chk_all();
        send(2, m2);
        img[0] = 8'haa;
        set_mask(m1 | m2);
        chk_all();
        check("compare_fail_out", {7'h00, fail}, 8'h01);
        send(2, 32'h0);
        img[0] = 8'hab;
        chk_all();
        send(2, 32'h0);
        img[0] = 8'ha9;
        set_mask(32'h0);
        chk_all();
        wr(7'h67, 8'h00);
        wr(7'h70, 8'hff);
        send(2, m1);
        img[0] = 8'h00;
        chk_all();
        // flags set, then a reset after the run has stopped must bring back every reset value
        wr(7'h67, 8'h88);
        send(2, m2);
        check("compare_fail_out", {7'h00, fail}, 8'h01);
        rst_b_in = 1'b0;
        repeat (3) @(negedge mclk_in);
        rst_b_in = 1'b1;
        img = rst_img;
        check("sample_err_out", {7'h00, sample_err}, 8'h00);
        check("compare_fail_out", {7'h00, fail}, 8'h00);
        chk_all();
        repeat (4) @(negedge mclk_in);
        tally_and_finish();
    end
endmodule

/* File: src/sedc_checker.sv */
// Operation
// - enable bit 7 gates all comparison
// - sample-error bit 5 sticky on mismatch
// - a control write clears bit 5 unless a mismatch arrives in the same cycle
// - autoclear bit 3 activates fail/pass bits
// - eight clean sets clear error masks
// - fail bit set on error, cleared
// - pass bit shows last comparison clean
// - first I reference word, high resets 7a
// - first Q reference word held, compared
// - control bits all zero after reset
// - second I and Q references held
// - 16-bit error masks per I/Q path
`timescale 1ns/1ps
`include "sedc_defines.svh"

module sedc_checker
    import sedc_pkg::*;
#(
    parameter int CLEAN_RUN = `SEDC_CLEAN_RUN
)
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // register port
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [6:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // captured sample pairs from the data port
    input wire logic beat_valid_in,
    input wire sedc_beat_s beat_in,
    // status levels
    output logic sample_err_out,
    output logic compare_fail_out
);

    // counter is 8 bits wide, so longer runs cannot be served
    if (CLEAN_RUN < 1 || CLEAN_RUN > 255) begin : g_bad_run
        $error("CLEAN_RUN out of range");
    end

    localparam logic [7:0] RUN_LAST = 8'(CLEAN_RUN - 1);

    logic enable_reg;
    logic autoclr_reg;
    logic sample_err_reg;
    logic fail_reg;
    logic pass_reg;
    logic [7:0] clean_cnt_reg;
    sedc_word_t err_i_reg;
    sedc_word_t err_q_reg;
    logic [7:0] ref_reg [0:7];
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    sedc_refpair_s ref_first;
    sedc_refpair_s ref_second;
    sedc_result_s res;
    logic ctrl_wr;
    logic res_err;
    logic run_done;

    function automatic logic [7:0] ctrl_image(input logic en, input logic serr, input logic ac,
                                              input logic fl, input logic ps);
        logic [7:0] v;
        v = 8'h00;
        v[`SEDC_BIT_ENABLE] = en;
        v[`SEDC_BIT_SAMPLE_ERR] = serr;
        v[`SEDC_BIT_AUTOCLR] = ac;
        v[`SEDC_BIT_FAIL] = fl;
        v[`SEDC_BIT_PASS] = ps;
        return v;
    endfunction

    function automatic logic [2:0] ref_index(input logic [6:0] addr);
        return addr[2:0];
    endfunction

    function automatic logic is_ref_addr(input logic [6:0] addr);
        return addr >= `SEDC_ADDR_I0_LO && addr <= `SEDC_ADDR_Q1_HI;
    endfunction

    // any control write counts as a clear, whatever the data
    assign ctrl_wr = reg_wr_in && reg_addr_in == `SEDC_ADDR_CTRL;
    assign res_err = res.valid && (|res.mism_i || |res.mism_q);
    assign run_done = res.valid && !res_err && autoclr_reg && clean_cnt_reg == RUN_LAST;

    // high byte at the odd address, no atomic update of a word
    assign ref_first.i_ref = {ref_reg[1], ref_reg[0]};
    assign ref_first.q_ref = {ref_reg[3], ref_reg[2]};
    assign ref_second.i_ref = {ref_reg[5], ref_reg[4]};
    assign ref_second.q_ref = {ref_reg[7], ref_reg[6]};

    sedc_compare u_compare (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .enable_in(enable_reg),
        .beat_valid_in(beat_valid_in),
        .beat_in(beat_in),
        .ref_first_in(ref_first),
        .ref_second_in(ref_second),
        .result_out(res)
    );

    // control bits
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            enable_reg <= 1'b0;
            autoclr_reg <= 1'b0;
        end else if (ctrl_wr) begin
            enable_reg <= reg_wdata_in[`SEDC_BIT_ENABLE];
            autoclr_reg <= reg_wdata_in[`SEDC_BIT_AUTOCLR];
        end
    end

    // reference words
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ref_reg[0] <= `SEDC_RST_I0_LO;
            ref_reg[1] <= `SEDC_RST_I0_HI;
            ref_reg[2] <= `SEDC_RST_Q0_LO;
            ref_reg[3] <= `SEDC_RST_Q0_HI;
            ref_reg[4] <= `SEDC_RST_I1_LO;
            ref_reg[5] <= `SEDC_RST_I1_HI;
            ref_reg[6] <= `SEDC_RST_Q1_LO;
            ref_reg[7] <= `SEDC_RST_Q1_HI;
        end else if (reg_wr_in && is_ref_addr(reg_addr_in)) begin
            ref_reg[ref_index(reg_addr_in)] <= reg_wdata_in;
        end
    end

    // sticky sample error: a mismatch wins over the clearing write
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sample_err_reg <= 1'b0;
        end else if (res_err) begin
            sample_err_reg <= 1'b1;
        end else if (ctrl_wr) begin
            sample_err_reg <= 1'b0;
        end
    end

    // error-free run counter
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            clean_cnt_reg <= 8'h00;
        end else if (!enable_reg || !autoclr_reg || res_err || run_done) begin
            clean_cnt_reg <= 8'h00;
        end else if (res.valid) begin
            clean_cnt_reg <= clean_cnt_reg + 8'h01;
        end
    end

    // fail and pass flags, live only in autoclear mode
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fail_reg <= 1'b0;
            pass_reg <= 1'b0;
        end else if (!autoclr_reg) begin
            fail_reg <= 1'b0;
            pass_reg <= 1'b0;
        end else begin
            if (res_err) begin
                fail_reg <= 1'b1;
            end else if (run_done || ctrl_wr) begin
                fail_reg <= 1'b0;
            end
            if (res.valid) begin
                pass_reg <= !res_err;
            end
        end
    end

    // per-bit error masks
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            err_i_reg <= '0;
            err_q_reg <= '0;
        end else if (run_done) begin
            err_i_reg <= '0;
            err_q_reg <= '0;
        end else if (res.valid) begin
            err_i_reg <= err_i_reg | res.mism_i;
            err_q_reg <= err_q_reg | res.mism_q;
        end
    end

    // read port, one cycle after the strobe
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_rd_in;
            if (reg_rd_in) begin
                if (is_ref_addr(reg_addr_in)) begin
                    rdata_reg <= ref_reg[ref_index(reg_addr_in)];
                end else begin
                    unique case (reg_addr_in)
                        `SEDC_ADDR_CTRL: rdata_reg <= ctrl_image(enable_reg, sample_err_reg, autoclr_reg,
                                                                 fail_reg, pass_reg);
                        `SEDC_ADDR_ERR_I_LO: rdata_reg <= err_i_reg[7:0];
                        `SEDC_ADDR_ERR_I_HI: rdata_reg <= err_i_reg[15:8];
                        `SEDC_ADDR_ERR_Q_LO: rdata_reg <= err_q_reg[7:0];
                        `SEDC_ADDR_ERR_Q_HI: rdata_reg <= err_q_reg[15:8];
                        default: rdata_reg <= 8'h00;
                    endcase
                end
            end
        end
    end

    assign reg_rdata_out = rdata_reg;
    assign reg_rvalid_out = rvalid_reg;
    assign sample_err_out = sample_err_reg;
    assign compare_fail_out = fail_reg;

    // checks
    a_off_quiet: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !enable_reg ##1 !enable_reg |-> !res.valid ##1 $stable(sample_err_reg) || $past(ctrl_wr))
        else $error("comparison active while disabled");

    a_err_sets: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        res_err |=> sample_err_reg ##1 (sample_err_reg || $past(ctrl_wr)))
        else $error("sample error flag not sticky");

    a_write_clears: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        ctrl_wr && !res_err |=> !sample_err_reg)
        else $error("control write did not clear sample error");

    a_modeoff_quiet: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !autoclr_reg |=> !fail_reg && !pass_reg || $past(ctrl_wr))
        else $error("fail/pass active outside autoclear");

    a_run_clears: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        run_done |=> err_i_reg == 16'h0000 && err_q_reg == 16'h0000 && !fail_reg)
        else $error("masks not cleared after clean run");

    a_fail_holds: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        autoclr_reg && res_err |=> fail_reg ##1 (fail_reg || $past(run_done) || $past(ctrl_wr)
                                               || !$past(autoclr_reg)))
        else $error("compare fail not held");

    a_pass_tracks: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        autoclr_reg && res.valid && !ctrl_wr |=> pass_reg == !$past(res_err))
        else $error("compare pass wrong");

    a_mask_accum: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        res_err |=> (err_i_reg & $past(res.mism_i)) == $past(res.mism_i)
                    && (err_q_reg & $past(res.mism_q)) == $past(res.mism_q))
        else $error("mismatch bits not kept in mask");

    a_cnt_bound: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        clean_cnt_reg <= RUN_LAST)
        else $error("clean run counter overran");

    a_off_novalid: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !enable_reg |=> !res.valid)
        else $error("result valid while disabled");

    a_enable_store: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        ctrl_wr |=> enable_reg == $past(reg_wdata_in[`SEDC_BIT_ENABLE]))
        else $error("enable bit not stored");

    a_ctrl_fail_clr: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        ctrl_wr && !res_err |=> !fail_reg)
        else $error("control write did not clear compare fail");

    a_cnt_restart: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        res_err |=> clean_cnt_reg == 8'h00)
        else $error("clean run counter not restarted by error");

    a_clean_keep: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !res_err && !run_done |=> $stable(err_i_reg) && $stable(err_q_reg))
        else $error("error mask changed without mismatch");

    a_ref_i0_hi: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        reg_wr_in && reg_addr_in == `SEDC_ADDR_I0_HI |=> ref_first.i_ref[15:8] == $past(reg_wdata_in))
        else $error("first I reference high byte not stored");

    a_ref_q0_lo: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        reg_wr_in && reg_addr_in == `SEDC_ADDR_Q0_LO |=> ref_first.q_ref[7:0] == $past(reg_wdata_in))
        else $error("first Q reference low byte not stored");

    a_ref_i1_lo: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        reg_wr_in && reg_addr_in == `SEDC_ADDR_I1_LO |=> ref_second.i_ref[7:0] == $past(reg_wdata_in))
        else $error("second I reference low byte not stored");

    a_ref_q1_hi: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        reg_wr_in && reg_addr_in == `SEDC_ADDR_Q1_HI |=> ref_second.q_ref[15:8] == $past(reg_wdata_in))
        else $error("second Q reference high byte not stored");

    a_mask_read: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        reg_rd_in && reg_addr_in == `SEDC_ADDR_ERR_Q_HI
        |=> reg_rvalid_out && reg_rdata_out == $past(err_q_reg[15:8]))
        else $error("error mask read wrong");

    a_ctrl_read: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        reg_rd_in && reg_addr_in == `SEDC_ADDR_CTRL
        |=> reg_rdata_out[`SEDC_BIT_ENABLE] == $past(enable_reg)
            && reg_rdata_out[`SEDC_BIT_SAMPLE_ERR] == $past(sample_err_reg))
        else $error("control read wrong");

endmodule

/* File: src/sedc_compare.sv */
`timescale 1ns/1ps
`include "sedc_defines.svh"

module sedc_compare
    import sedc_pkg::*;
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // control
    input wire logic enable_in,
    // sample beat
    input wire logic beat_valid_in,
    input wire sedc_beat_s beat_in,
    // references for first and second beat
    input wire sedc_refpair_s ref_first_in,
    input wire sedc_refpair_s ref_second_in,
    // registered comparison result
    output sedc_result_s result_out
);

    sedc_phase_e phase_reg;
    sedc_result_s result_reg;
    sedc_refpair_s ref_sel;

    assign ref_sel = (phase_reg == SEDC_PH_FIRST) ? ref_first_in : ref_second_in;
    assign result_out = result_reg;

    // pattern alternates first/second pair, realigned on disable
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            phase_reg <= SEDC_PH_FIRST;
        end else if (!enable_in) begin
            phase_reg <= SEDC_PH_FIRST;
        end else if (beat_valid_in) begin
            phase_reg <= (phase_reg == SEDC_PH_FIRST) ? SEDC_PH_SECOND : SEDC_PH_FIRST;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            result_reg <= '0;
        end else begin
            result_reg.valid <= enable_in && beat_valid_in;
            result_reg.mism_i <= beat_in.i_word ^ ref_sel.i_ref;
            result_reg.mism_q <= beat_in.q_word ^ ref_sel.q_ref;
        end
    end

endmodule

/* File: src/sedc_defines.svh */
`ifndef SEDC_DEFINES_SVH
`define SEDC_DEFINES_SVH

// register addresses
`define SEDC_ADDR_CTRL 7'h67
`define SEDC_ADDR_I0_LO 7'h68
`define SEDC_ADDR_I0_HI 7'h69
`define SEDC_ADDR_Q0_LO 7'h6a
`define SEDC_ADDR_Q0_HI 7'h6b
`define SEDC_ADDR_I1_LO 7'h6c
`define SEDC_ADDR_I1_HI 7'h6d
`define SEDC_ADDR_Q1_LO 7'h6e
`define SEDC_ADDR_Q1_HI 7'h6f
`define SEDC_ADDR_ERR_I_LO 7'h70
`define SEDC_ADDR_ERR_I_HI 7'h71
`define SEDC_ADDR_ERR_Q_LO 7'h72
`define SEDC_ADDR_ERR_Q_HI 7'h73

// control/status bit positions
`define SEDC_BIT_ENABLE 7
`define SEDC_BIT_SAMPLE_ERR 5
`define SEDC_BIT_AUTOCLR 3
`define SEDC_BIT_FAIL 1
`define SEDC_BIT_PASS 0

// reset values
`define SEDC_RST_I0_LO 8'h00
`define SEDC_RST_I0_HI 8'h7a
`define SEDC_RST_Q0_LO 8'h00
`define SEDC_RST_Q0_HI 8'hea
`define SEDC_RST_I1_LO 8'h16
`define SEDC_RST_I1_HI 8'h1a
`define SEDC_RST_Q1_LO 8'h00
`define SEDC_RST_Q1_HI 8'haa

// error-free data sets before autoclear
`define SEDC_CLEAN_RUN 8

`endif

/* File: src/sedc_pkg.sv */
package sedc_pkg;

    typedef logic [15:0] sedc_word_t;

    typedef enum logic {
        SEDC_PH_FIRST = 1'b0,
        SEDC_PH_SECOND = 1'b1
    } sedc_phase_e;

    typedef struct packed {
        sedc_word_t i_word;
        sedc_word_t q_word;
    } sedc_beat_s;

    typedef struct packed {
        sedc_word_t i_ref;
        sedc_word_t q_ref;
    } sedc_refpair_s;

    typedef struct packed {
        logic valid;
        sedc_word_t mism_i;
        sedc_word_t mism_q;
    } sedc_result_s;

endpackage
